// file: verilog/slicer_pkg.sv
`default_nettype none
package slicer_pkg;
	// ************************************************************
	// register indices (byte address = index * 4)
	// ************************************************************
	localparam logic [11:0] IDX_CLK_CFG    = 12'hFD8;
	localparam logic [11:0] IDX_SYNC_SLICE = 12'hFD9;
	localparam logic [11:0] IDX_DATA_SLICE = 12'hFDA;
	localparam logic [11:0] IDX_FIRST      = 12'hFDB;
	localparam logic [11:0] IDX_SECOND     = 12'hFDC;
	localparam logic [11:0] IDX_STATUS     = 12'hFDD;
	localparam logic [11:0] IDX_MODE       = 12'hFDF;
	localparam logic [7:0]  SYNC_SLICE_RST = 8'h42;
	localparam logic [5:0]  DATA_SLICE_RST = 6'h20;
	localparam logic [7:0]  MODE_RST       = 8'h1B;
	localparam logic [7:0]  CLK_CFG_RST    = 8'h00;
	localparam int          MODE_INV_BIT   = 6;
	localparam int          MODE_EXT_BIT   = 5;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int          CLK_NS         = 100;
	localparam int          LINE_NS        = 63500;
	localparam int          HGAP_NS        = 40000;
	localparam int          VSYNC_NS       = 20000;
	localparam int          CLAMP_NS       = 2500;
	localparam int          RUNIN_BEG_NS   = 10500;
	localparam int          RUNIN_END_NS   = 24500;
	localparam logic [9:0]  LINE_C         = 10'(LINE_NS / CLK_NS);
	localparam logic [9:0]  HGAP_C         = 10'((HGAP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [9:0]  RUNIN_BEG_C    = 10'((RUNIN_BEG_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [9:0]  RUNIN_END_C    = 10'(RUNIN_END_NS / CLK_NS);
	localparam logic [8:0]  VSYNC_C        = 9'((VSYNC_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [5:0]  CLAMP_C        = 6'((CLAMP_NS + CLK_NS - 1) / CLK_NS);
	// ************************************************************
	// lines, lock, sampling
	// ************************************************************
	localparam int          FIELD_STD_LINES = 263;
	localparam logic [8:0]  FIELD_STD      = 9'(FIELD_STD_LINES);
	localparam logic [8:0]  FIELD_LO       = 9'(FIELD_STD_LINES - 16);
	localparam logic [8:0]  FIELD_HI       = 9'(FIELD_STD_LINES + 16);
	localparam logic [8:0]  LINE_BASE      = 9'h009;
	localparam logic [8:0]  VSYNC_LINE     = 9'h004;
	localparam logic [4:0]  FIELD_LINE_COUNT_ADJ      = 5'h10;
	localparam logic [3:0]  RUNIN_MIN      = 4'h3;
	localparam logic [5:0]  SLICE_BAL      = 6'h02;
	localparam int          BIT_KHZ        = 503;
	localparam int          SYS_KHZ        = 1000000 / CLK_NS;
	localparam int          NCO_INC        = 65536 * BIT_KHZ / SYS_KHZ;
	localparam int          INC_PER_CYC    = NCO_INC / (LINE_NS / CLK_NS);
	localparam logic [15:0] PHASE_HALF     = 16'h8000;
	typedef enum logic [2:0] {S_IDLE, S_RUNIN, S_HUNT, S_SHIFT, S_DONE} samp_state_t;
endpackage
`default_nettype wire

// file: verilog/slicer_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface slicer_link_if;
	logic              data_bit;
	logic              caption_line;
	logic              runin_win;
	logic              vsync;
	logic signed [7:0] h_delta;
	logic              runin_seen;
	logic [3:0]        runin_cnt;
	logic              start_seen;
	logic              word_seen;
	logic              word_done;
	logic [15:0]       word;
	modport timing (output data_bit, caption_line, runin_win, vsync, h_delta,
		input runin_seen, runin_cnt, start_seen, word_seen, word_done, word);
	modport sampler (input data_bit, caption_line, runin_win, vsync, h_delta,
		output runin_seen, runin_cnt, start_seen, word_seen, word_done, word);
endinterface
`default_nettype wire

// file: verilog/caption_sampler.sv
`timescale 1ns/1ps
`default_nettype none
module caption_sampler (
	// clock and reset
	input  wire logic           i_sys_clk,
	input  wire logic           i_rstn,
	// link to timing
	slicer_link_if.sampler      lnk
);
	import slicer_pkg::*;

	samp_state_t state_q;
	logic [15:0] phase_q;
	logic [15:0] inc;
	logic [16:0] sum;
	logic        strobe;
	logic        dat_prev_q;
	logic        rise;
	logic [3:0]  cnt_q;
	logic [3:0]  nbit_q;
	logic [15:0] sh_q;

	// ************************************************************
	// sampling clock
	// ************************************************************
	assign inc = 16'(NCO_INC) - 16'(int'(lnk.h_delta) * INC_PER_CYC);
	assign sum = {1'b0, phase_q} + {1'b0, inc};
	assign strobe = sum[16];
	assign rise = lnk.data_bit & ~dat_prev_q;

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			phase_q <= 16'h0000;
			dat_prev_q <= 1'b0;
		end else begin
			dat_prev_q <= lnk.data_bit;
			if (state_q == S_RUNIN && rise)
				phase_q <= PHASE_HALF;
			else
				phase_q <= sum[15:0];
		end
	end

	// ************************************************************
	// run-in, start bit and 16-bit word
	// ************************************************************
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q <= S_IDLE;
			cnt_q <= 4'h0;
			nbit_q <= 4'h0;
			sh_q <= 16'h0000;
			lnk.word <= 16'h0000;
			lnk.word_done <= 1'b0;
		end else begin
			lnk.word_done <= 1'b0;
			if (!lnk.caption_line) begin
				state_q <= S_IDLE;
			end else begin
				unique case (state_q)
					S_IDLE: if (lnk.runin_win) begin
						state_q <= S_RUNIN;
						cnt_q <= 4'h0;
					end
					S_RUNIN: if (!lnk.runin_win) begin
						state_q <= S_HUNT;
					end else if (rise && cnt_q != 4'hF) begin
						cnt_q <= cnt_q + 4'h1;
					end
					S_HUNT: if (strobe && lnk.data_bit) begin
						state_q <= S_SHIFT;
						nbit_q <= 4'h0;
					end
					S_SHIFT: if (strobe) begin
						sh_q <= {lnk.data_bit, sh_q[15:1]};
						nbit_q <= nbit_q + 4'h1;
						if (nbit_q == 4'hF) begin
							state_q <= S_DONE;
							lnk.word <= {lnk.data_bit, sh_q[15:1]};
							lnk.word_done <= 1'b1;
						end
					end
					S_DONE: state_q <= S_DONE;
				endcase
			end
		end
	end

	assign lnk.runin_cnt = cnt_q;
	assign lnk.runin_seen = cnt_q >= RUNIN_MIN;

	// flags hold until vertical sync; a set in the same cycle wins
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			lnk.start_seen <= 1'b0;
			lnk.word_seen <= 1'b0;
		end else begin
			if (state_q == S_HUNT && strobe && lnk.data_bit && lnk.caption_line)
				lnk.start_seen <= 1'b1;
			else if (lnk.vsync)
				lnk.start_seen <= 1'b0;
			if (lnk.word_done)
				lnk.word_seen <= 1'b1;
			else if (lnk.vsync)
				lnk.word_seen <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// file: verilog/caption_data_slicer.sv
// How it works
// - upper nibble rising, lower nibble falling
// - sync threshold is 3+3n over 512
// - data threshold is n+1 over 256
// - data slice read returns corrected level
// - detect hsync, generate pedestal clamp pulse
// - measure line period variation for sampler
// - caption line signal from line count
// - detect run-in, adjust data slice level
// - sampling clock locks to run-in edges
// - sampling clock shifted by line variation
// - caption bits shift into 16-bit word
// - interrupt on caption line rising edge
// - external sync pin when select bit set
// - optional inversion, internal sync active low
// - lock bit shows vertical synchronisation
// - field lines minus 263, two's complement
// - standard reads 00H, adjusting reads 10H
// - correction starts from programmed code
`timescale 1ns/1ps
`default_nettype none
module caption_data_slicer (
	// clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_rstn,
	// avalon-mm slave
	input  wire logic [13:0] i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic [31:0]      o_avs_readdata,
	output logic             o_avs_waitrequest,
	// comparators and sync pin
	input  wire logic        i_sync_cmp_n,
	input  wire logic        i_ext_sync_pin,
	input  wire logic        i_data_cmp,
	// analog controls
	output logic [5:0]       o_sync_thresh_num,
	output logic [6:0]       o_data_thresh_num,
	output logic             o_clamp_pulse,
	output logic [7:0]       o_slicer_clock_config,
	// events
	output logic             o_caption_irq
);
	import slicer_pkg::*;

	slicer_link_if lnk ();

	logic [2:0]        meta_q;
	logic [2:0]        pin_q;
	logic [7:0]        sync_code_q;
	logic [5:0]        prog_lvl_q;
	logic [7:0]        mode_q;
	logic [7:0]        first_q;
	logic [7:0]        second_q;
	logic              csync_n_q;
	logic              csync_prev_q;
	logic              fall;
	logic              rise;
	logic [9:0]        since_h_q;
	logic              hsync;
	logic [8:0]        low_q;
	logic              vsync;
	logic [5:0]        clamp_q;
	logic [8:0]        line_q;
	logic [8:0]        fcnt_q;
	logic [1:0]        good_q;
	logic              lock;
	logic [4:0]        field_line_count_q;
	logic              field_q;
	logic signed [7:0] h_delta_q;
	logic [10:0]       dlt;
	logic              cap_d;
	logic              cap_q;
	logic              irq_q;
	logic              win_q;
	logic              win_prev_q;
	logic              dat_prev_q;
	logic [5:0]        work_q;
	logic [5:0]        final_q;
	logic [5:0]        hi_q;
	logic [5:0]        lo_q;
	logic              ack_q;
	logic              req;
	logic [11:0]       idx;
	logic [7:0]        rd8;

	function automatic logic [5:0] thr_sync(input logic [3:0] n);
		thr_sync = 6'h03 + 6'(n) * 6'h03;
	endfunction

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			meta_q <= 3'h3;
			pin_q <= 3'h3;
		end else begin
			meta_q <= {i_data_cmp, i_ext_sync_pin, i_sync_cmp_n};
			pin_q <= meta_q;
		end
	end

	// ************************************************************
	// sync source and slice codes
	// ************************************************************
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			csync_n_q <= 1'b1;
			csync_prev_q <= 1'b1;
			o_sync_thresh_num <= 6'h03;
			o_data_thresh_num <= 7'h01;
		end else begin
			csync_prev_q <= csync_n_q;
			if (mode_q[MODE_EXT_BIT])
				csync_n_q <= pin_q[1] ^ mode_q[MODE_INV_BIT];
			else
				csync_n_q <= pin_q[0];
			if (!csync_n_q)
				o_sync_thresh_num <= thr_sync(sync_code_q[7:4]);
			else
				o_sync_thresh_num <= thr_sync(sync_code_q[3:0]);
			o_data_thresh_num <= 7'(cap_q ? work_q : prog_lvl_q) + 7'h01;
		end
	end

	assign fall = csync_prev_q & ~csync_n_q;
	assign rise = ~csync_prev_q & csync_n_q;
	assign hsync = fall && since_h_q >= HGAP_C;
	assign vsync = !csync_n_q && low_q == VSYNC_C;

	// ************************************************************
	// horizontal timing
	// ************************************************************
	assign dlt = {1'b0, since_h_q} + 11'h001 - {1'b0, LINE_C};

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			since_h_q <= 10'h000;
			low_q <= 9'h000;
			clamp_q <= 6'h00;
			h_delta_q <= 8'sh00;
		end else begin
			if (hsync)
				since_h_q <= 10'h000;
			else if (since_h_q != 10'h3FF)
				since_h_q <= since_h_q + 10'h001;
			if (csync_n_q)
				low_q <= 9'h000;
			else if (low_q != 9'h1FF)
				low_q <= low_q + 9'h001;
			if (rise)
				clamp_q <= CLAMP_C;
			else if (clamp_q != 6'h00)
				clamp_q <= clamp_q - 6'h01;
			if (hsync && since_h_q != 10'h3FF) begin
				if ($signed(dlt) > 11'sh07F)
					h_delta_q <= 8'sh7F;
				else if ($signed(dlt) < -11'sh080)
					h_delta_q <= -8'sh80;
				else
					h_delta_q <= dlt[7:0];
			end
		end
	end

	assign o_clamp_pulse = clamp_q != 6'h00;

	// ************************************************************
	// vertical timing and lock
	// ************************************************************
	assign lock = good_q == 2'h2;
	assign cap_d = line_q == {5'h00, mode_q[3:0]} + LINE_BASE;

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			line_q <= 9'h000;
			fcnt_q <= 9'h000;
			good_q <= 2'h0;
			field_line_count_q <= FIELD_LINE_COUNT_ADJ;
			field_q <= 1'b0;
			cap_q <= 1'b0;
			irq_q <= 1'b0;
			win_q <= 1'b0;
		end else begin
			cap_q <= cap_d;
			irq_q <= cap_d & ~cap_q;
			win_q <= cap_q && since_h_q >= RUNIN_BEG_C && since_h_q < RUNIN_END_C;
			if (vsync) begin
				line_q <= VSYNC_LINE;
				fcnt_q <= 9'h000;
				field_line_count_q <= 5'(fcnt_q - FIELD_STD);
				field_q <= since_h_q >= HGAP_C;
				if (fcnt_q >= FIELD_LO && fcnt_q <= FIELD_HI)
					good_q <= lock ? 2'h2 : good_q + 2'h1;
				else
					good_q <= 2'h0;
			end else if (hsync) begin
				if (line_q != 9'h1FF)
					line_q <= line_q + 9'h001;
				if (fcnt_q != 9'h1FF)
					fcnt_q <= fcnt_q + 9'h001;
				if (fcnt_q > FIELD_HI)
					good_q <= 2'h0;
			end
		end
	end

	assign o_caption_irq = irq_q;

	// ************************************************************
	// slice level control
	// ************************************************************
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			win_prev_q <= 1'b0;
			dat_prev_q <= 1'b0;
			work_q <= DATA_SLICE_RST;
			final_q <= DATA_SLICE_RST;
			hi_q <= 6'h00;
			lo_q <= 6'h00;
		end else begin
			win_prev_q <= win_q;
			dat_prev_q <= pin_q[2];
			if (win_q && !win_prev_q) begin
				work_q <= prog_lvl_q;
				hi_q <= 6'h00;
				lo_q <= 6'h00;
			end else if (win_q) begin
				if (pin_q[2] && !dat_prev_q) begin
					hi_q <= 6'h00;
					lo_q <= 6'h00;
					if (hi_q > lo_q + SLICE_BAL && work_q != 6'h3F)
						work_q <= work_q + 6'h01;
					else if (lo_q > hi_q + SLICE_BAL && work_q != 6'h00)
						work_q <= work_q - 6'h01;
				end else if (pin_q[2]) begin
					if (hi_q != 6'h3F)
						hi_q <= hi_q + 6'h01;
				end else if (lo_q != 6'h3F) begin
					lo_q <= lo_q + 6'h01;
				end
			end else if (win_prev_q) begin
				final_q <= work_q;
			end
		end
	end

	// ************************************************************
	// sampler link
	// ************************************************************
	assign lnk.data_bit = pin_q[2];
	assign lnk.caption_line = cap_q;
	assign lnk.runin_win = win_q;
	assign lnk.vsync = vsync;
	assign lnk.h_delta = h_delta_q;

	caption_sampler u_sampler (
		.i_sys_clk (i_sys_clk),
		.i_rstn    (i_rstn),
		.lnk       (lnk.sampler)
	);

	// ************************************************************
	// register bus
	// ************************************************************
	assign req = i_avs_read | i_avs_write;
	assign idx = i_avs_address[13:2];
	assign o_avs_waitrequest = req & ~ack_q;

	always_comb begin
		unique case (idx)
			IDX_CLK_CFG:    rd8 = o_slicer_clock_config;
			IDX_DATA_SLICE: rd8 = {2'h0, final_q};
			IDX_FIRST:      rd8 = first_q;
			IDX_SECOND:     rd8 = second_q;
			IDX_STATUS:     rd8 = {lnk.runin_seen, 4'(lnk.runin_cnt - 4'h1), field_q,
				lnk.start_seen, lnk.word_seen};
			IDX_MODE:       rd8 = {2'h0, lock, lock ? field_line_count_q : FIELD_LINE_COUNT_ADJ};
			default:        rd8 = 8'h00;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ack_q <= 1'b0;
			o_avs_readdata <= 32'h0000_0000;
		end else begin
			ack_q <= req & ~ack_q;
			if (i_avs_read && !ack_q)
				o_avs_readdata <= {24'h000000, rd8};
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sync_code_q <= SYNC_SLICE_RST;
			prog_lvl_q <= DATA_SLICE_RST;
			mode_q <= MODE_RST;
			o_slicer_clock_config <= CLK_CFG_RST;
		end else if (i_avs_write && ack_q && i_avs_byteenable[0]) begin
			unique case (idx)
				IDX_CLK_CFG:    o_slicer_clock_config <= i_avs_writedata[7:0];
				IDX_SYNC_SLICE: sync_code_q <= i_avs_writedata[7:0];
				IDX_DATA_SLICE: prog_lvl_q <= i_avs_writedata[5:0];
				IDX_MODE:       mode_q <= {1'b0, i_avs_writedata[6:5], 1'b1, i_avs_writedata[3:0]};
				default:        mode_q <= mode_q;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			first_q <= 8'h00;
			second_q <= 8'h00;
		end else if (lnk.word_done) begin
			first_q <= lnk.word[7:0];
			second_q <= lnk.word[15:8];
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rstn);

	property p_sync_nibble;
		$past(i_rstn) |->
			o_sync_thresh_num == thr_sync($past(csync_n_q) ? $past(sync_code_q[3:0]) : $past(sync_code_q[7:4]));
	endproperty
	a_sync_nibble: assert property (p_sync_nibble) else $error("sync slice nibble wrong");

	property p_sync_range;
		o_sync_thresh_num >= 6'h03 && o_sync_thresh_num <= 6'h30 && o_sync_thresh_num % 3 == 0;
	endproperty
	a_sync_range: assert property (p_sync_range) else $error("sync threshold out of range");

	property p_data_thr;
		$past(i_rstn) |->
			o_data_thresh_num == 7'($past(cap_q) ? $past(work_q) : $past(prog_lvl_q)) + 7'h01;
	endproperty
	a_data_thr: assert property (p_data_thr) else $error("data threshold wrong");

	property p_read_final;
		(i_avs_read && !ack_q && idx == IDX_DATA_SLICE) |=> o_avs_readdata[5:0] == $past(final_q);
	endproperty
	a_read_final: assert property (p_read_final) else $error("slice read not final level");

	property p_start_level;
		(win_q && !win_prev_q) |=> work_q == $past(prog_lvl_q);
	endproperty
	a_start_level: assert property (p_start_level) else $error("correction start level wrong");

	property p_irq;
		o_caption_irq == (cap_q && !$past(cap_q));
	endproperty
	a_irq: assert property (p_irq) else $error("irq not on caption rise");

	property p_unlocked;
		(i_avs_read && !ack_q && idx == IDX_MODE && !lock) |=> o_avs_readdata[5:0] == 6'h10;
	endproperty
	a_unlocked: assert property (p_unlocked) else $error("unlocked monitor wrong");

	property p_ext_sync;
		mode_q[MODE_EXT_BIT] |=> csync_n_q == ($past(pin_q[1]) ^ $past(mode_q[MODE_INV_BIT]));
	endproperty
	a_ext_sync: assert property (p_ext_sync) else $error("external sync path wrong");

	property p_hgap;
		hsync |=> !hsync [*8];
	endproperty
	a_hgap: assert property (p_hgap) else $error("hsync too close");

	c_irq: cover property (o_caption_irq);
	c_word: cover property (lnk.word_done);
	c_lock: cover property ($rose(lock));
endmodule
`default_nettype wire

// file: bench/video_source.sv
`timescale 1ns/1ps
`default_nettype none
module video_source #(
	parameter int FIELD_LINES = 22
) (
	// clock and controls
	input  wire logic        i_sys_clk,
	input  wire logic        i_run,
	input  wire logic        i_int_quiet,
	input  wire logic        i_ext_high,
	input  wire logic [15:0] i_word,
	input  wire logic [6:0]  i_data_thresh_num,
	// comparators and sync pin
	output logic             o_sync_cmp_n,
	output logic             o_ext_sync_pin,
	output logic             o_data_cmp
);
	// ****
	// line and field counters, line 0 carries a long sync
	// ****
	int   pos;
	int   line;
	int   lvl;
	int   ph;
	logic tip;
	always_ff @(posedge i_sys_clk) begin
		if (!i_run) begin
			pos <= 0;
			line <= 0;
		end else if (pos == 634) begin
			pos <= 0;
			line <= (line == FIELD_LINES - 1) ? 0 : line + 1;
		end else begin
			pos <= pos + 1;
		end
	end
	// ****
	// video level: run-in triangle, start bit, 16 bits lsb first
	// ****
	always_comb begin
		tip = i_run && (line == 0 ? pos < 300 : pos < 47);
		ph = (pos - 110) % 20;
		lvl = 0;
		if (i_run && line != 0) begin
			if (pos >= 110 && pos < 230)
				lvl = (ph < 10) ? ph * 6 : (20 - ph) * 6;
			else if (pos >= 250 && pos < 270)
				lvl = 60;
			else if (pos >= 270 && pos < 590)
				lvl = i_word[(pos - 270) / 20] ? 60 : 0;
		end
	end
	assign o_sync_cmp_n   = ~(tip & ~i_int_quiet);
	assign o_ext_sync_pin = i_ext_high ? tip : ~tip;
	assign o_data_cmp     = lvl > int'(i_data_thresh_num);
endmodule
`default_nettype wire

// file: bench/caption_data_slicer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module caption_data_slicer_tb_top;
	import slicer_pkg::*;
	localparam int FL = 22;
	logic        sys_clk, rstn, rd, wr, run, quiet, ext_hi, cmp_n, ext_pin, dcmp, irq, clamp, wreq;
	logic [13:0] addr;
	logic [31:0] wdata, rdata, seed;
	logic [3:0]  be;
	logic [5:0]  sth;
	logic [6:0]  dth;
	logic [7:0]  ccfg, v, fin0;
	logic [15:0] word;
	logic        seen_a, seen_b;
	int          mismatches, n_tests, irq_cnt, irq_len, clamp_len, ic, cc, n0;
	caption_data_slicer dut_u (.i_sys_clk(sys_clk), .i_rstn(rstn), .i_avs_address(addr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wreq), .i_sync_cmp_n(cmp_n), .i_ext_sync_pin(ext_pin), .i_data_cmp(dcmp),
		.o_sync_thresh_num(sth), .o_data_thresh_num(dth), .o_clamp_pulse(clamp),
		.o_slicer_clock_config(ccfg), .o_caption_irq(irq));
	video_source #(.FIELD_LINES(FL)) src_u (.i_sys_clk(sys_clk), .i_run(run), .i_int_quiet(quiet),
		.i_ext_high(ext_hi), .i_word(word), .i_data_thresh_num(dth), .o_sync_cmp_n(cmp_n),
		.o_ext_sync_pin(ext_pin), .o_data_cmp(dcmp));
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	// ****
	// helpers
	// ****
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] d, input logic [3:0] b);
		@(posedge sys_clk);
		addr <= {idx, 2'b00};
		rd <= ~w;
		wr <= w;
		wdata <= {24'h000000, d};
		be <= b;
		do begin
			@(posedge sys_clk);
		end while (wreq !== 1'b0);
		v = rdata[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic wirq(input int lim);
		int k;
		k = 0;
		while (irq !== 1'b1 && k < lim) begin
			@(negedge sys_clk);
			k++;
		end
	endtask
	task automatic give_verdict;
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ****
	// pulse length and threshold monitors
	// ****
	always @(posedge sys_clk) begin
		ic <= (irq === 1'b1) ? ic + 1 : 0;
		cc <= (clamp === 1'b1) ? cc + 1 : 0;
		if (irq !== 1'b1 && ic != 0) irq_len <= ic;
		if (clamp !== 1'b1 && cc != 0) clamp_len <= cc;
		if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
		if (run === 1'b1 && sth === 6'h12) seen_a <= 1'b1;
		if (run === 1'b1 && sth === 6'h21) seen_b <= 1'b1;
	end
	initial begin
		repeat (95000) @(posedge sys_clk);
		mismatches++;
		give_verdict();
	end
	// ****
	// main sequence
	// ****
	initial begin
		seed = 32'h00005CBC;
		{rstn, rd, wr, run, quiet, ext_hi, seen_a, seen_b} = 8'h00;
		addr = 14'h0000;
		wdata = 32'h00000000;
		be = 4'h0;
		word = 16'h0000;
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		bus(1'b0, IDX_MODE, 8'h00, 4'hF);
		chk("monitor", 16'h0010, {8'h00, v});
		bus(1'b1, IDX_CLK_CFG, 8'h02, 4'hF);
		bus(1'b1, IDX_CLK_CFG, 8'h00, 4'h0);
		bus(1'b0, IDX_CLK_CFG, 8'h00, 4'hF);
		chk("clk_cfg", 16'h0002, {8'h00, v});
		chk("clk_out", 16'h0002, {8'h00, ccfg});
		bus(1'b0, 12'hFDE, 8'h00, 4'hF);
		chk("unmapped", 16'h0000, {8'h00, v});
		bus(1'b0, IDX_SYNC_SLICE, 8'h00, 4'hF);
		chk("wo_read", 16'h0000, {8'h00, v});
		for (int n = 0; n < 16; n++) begin
			bus(1'b1, IDX_SYNC_SLICE, 8'(n * 17), 4'hF);
			repeat (3) @(posedge sys_clk);
			chk("sync_th", 16'(3 + 3 * n), {10'h000, sth});
		end
		for (int n = 0; n < 64; n++) begin
			bus(1'b1, IDX_DATA_SLICE, 8'(n), 4'hF);
			repeat (3) @(posedge sys_clk);
			chk("data_th", 16'(n + 1), {9'h000, dth});
		end
		bus(1'b1, IDX_SYNC_SLICE, 8'h5A, 4'hF);
		bus(1'b1, IDX_DATA_SLICE, 8'h00, 4'hF);
		for (int f = 0; f < 4; f++) begin
			seed = xs(seed);
			@(posedge sys_clk);
			word <= seed[15:0];
			if (f == 3) begin
				quiet <= 1'b1;
				ext_hi <= 1'b1;
				bus(1'b1, IDX_MODE, 8'h7B, 4'hF);
			end
			run <= 1'b1;
			wirq(2 * FL * 635);
			chk("irq", 16'h0001, {15'h0000, irq});
			repeat (700) @(posedge sys_clk);
			bus(1'b0, IDX_FIRST, 8'h00, 4'hF);
			chk("first", {8'h00, seed[7:0]}, {8'h00, v});
			bus(1'b0, IDX_SECOND, 8'h00, 4'hF);
			chk("second", {8'h00, seed[15:8]}, {8'h00, v});
			bus(1'b0, IDX_STATUS, 8'h00, 4'hF);
			chk("status", 16'h00AB, {8'h00, v & 8'hFB});
			bus(1'b0, IDX_DATA_SLICE, 8'h00, 4'hF);
			chk("corrected", 16'h0001, 16'(v != 8'h00));
			if (f == 0) fin0 = v;
			chk("th_start", {8'h00, fin0}, {8'h00, v});
			bus(1'b0, IDX_MODE, 8'h00, 4'hF);
			chk("monitor", 16'h0010, {8'h00, v});
		end
		chk("clamp_len", 16'h0019, 16'(clamp_len));
		chk("irq_len", 16'h0001, 16'(irq_len));
		chk("sync_both", 16'h0003, {14'h0000, seen_a, seen_b});
		bus(1'b1, IDX_MODE, 8'h1B, 4'hF);
		n0 = irq_cnt;
		repeat (FL * 635 + 700) @(posedge sys_clk);
		chk("no_irq", 16'(n0), 16'(irq_cnt));
		ext_hi <= 1'b0;
		bus(1'b1, IDX_MODE, 8'h3B, 4'hF);
		wirq(2 * FL * 635);
		chk("irq_ext", 16'h0001, {15'h0000, irq});
		give_verdict();
	end
endmodule
`default_nettype wire
